// ==== core/rcwd_pkg.sv ====
// How it works
// - data variant: first five digits are address
// - first word match stores nibble only
// - second word matching copies nibble out
// - flag rises with latch, drops on error/idle
// - open data digit decodes as one
// - address variant: nine digits, two words
// - every address digit equals local trinary setting
// - pulse narrow/wide threshold 1.72 encoder clocks
// - end of transmission after 33.5 encoder clocks
// - inter-word gap at 0.4 of that
// - digit pairs: short-short zero, long-long one, long-short open
package rcwd_pkg;

  // ------------------------------------------------------------
  // trinary digit coding and timing
  // ------------------------------------------------------------
  localparam logic [1:0] DIG_ZERO = 2'h0;
  localparam logic [1:0] DIG_ONE = 2'h1;
  localparam logic [1:0] DIG_OPEN = 2'h2;
  localparam int WORD_DIGITS = 9;
  localparam int ADDR_DIGITS_DATA = 5;
  // encoder clock period in ns and derived system clock counts
  localparam int CLK_PERIOD_NS = 100;
  localparam int ENC_PERIOD_NS = 10000;
  // thresholds scaled by 100 to keep 1.72 and 33.5 exact
  localparam int WIDE_X100 = 172;
  localparam int EOT_X100 = 3350;
  localparam int GAP_X10 = 4;
  localparam int WIDE_CYC = (WIDE_X100 * ENC_PERIOD_NS) / (100 * CLK_PERIOD_NS);
  localparam int EOT_CYC = (EOT_X100 * ENC_PERIOD_NS) / (100 * CLK_PERIOD_NS);
  localparam int GAP_CYC = (EOT_CYC * GAP_X10) / 10;

  typedef enum logic [2:0] {
    RCWD_FIRST = 3'h1,
    RCWD_SECOND = 3'h2,
    RCWD_HOLD = 3'h4
  } rcwd_phase_t;

  typedef struct packed {
    rcwd_phase_t phase;
    logic din_q;
    logic [15:0] hi_cnt;
    logic [15:0] lo_cnt;
    logic half;
    logic first_wide;
    logic [3:0] dig_idx;
    logic word_bad;
    logic [3:0] nib_work;
    logic [3:0] nib_store;
    logic [3:0] nib_out;
    logic flag;
    logic gap_seen;
  } rcwd_state_t;

endpackage : rcwd_pkg

// ==== core/rcwd_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
module rcwd_decoder #(
  parameter bit DATA_VARIANT = 1'b1,
  parameter int WIDE_CYC = rcwd_pkg::WIDE_CYC,
  parameter int GAP_CYC = rcwd_pkg::GAP_CYC,
  parameter int EOT_CYC = rcwd_pkg::EOT_CYC
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic serial_in,
  input wire logic [17:0] local_addr_digits,
  output logic word_pair_ok,
  output logic [3:0] nibble_outputs
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  rcwd_pkg::rcwd_state_t s_q, s_d;
  logic [1:0] dig;
  logic wide;
  logic addr_ok;
  int n_addr;
  logic fall_edge;
  logic gap_hit;
  logic eot_hit;
  logic [1:0] nib_pos;

  assign n_addr = DATA_VARIANT ? rcwd_pkg::ADDR_DIGITS_DATA : rcwd_pkg::WORD_DIGITS;

  // ------------------------------------------------------------
  // line events
  // ------------------------------------------------------------
  // a pulse is only measured once the line drops back low
  assign fall_edge = s_q.din_q && !serial_in;

  // word end, at most once per low run
  assign gap_hit = !serial_in && (s_q.lo_cnt == 16'(GAP_CYC)) && !s_q.gap_seen;

  // end of transmission on long idle
  assign eot_hit = !serial_in && (s_q.lo_cnt == 16'(EOT_CYC));

  // data digits sit after the address, cut to a nibble index
  assign nib_pos = 2'(s_q.dig_idx - 4'(rcwd_pkg::ADDR_DIGITS_DATA));

  assign wide = (s_q.hi_cnt >= 16'(WIDE_CYC));

  always_comb begin
    if (s_q.first_wide && wide) begin
      dig = rcwd_pkg::DIG_ONE;
    end else if (s_q.first_wide) begin
      dig = rcwd_pkg::DIG_OPEN;
    end else if (!wide) begin
      dig = rcwd_pkg::DIG_ZERO;
    end else begin
      dig = 2'h3;
    end
  end

  assign addr_ok = (dig == local_addr_digits[2*s_q.dig_idx +: 2]);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // end of transmission is judged last so that it wins over a word end
  always_comb begin
    s_d = s_q;
    s_d.din_q = serial_in;
    // widths counted in clocks
    // counters saturate so a dead line never wraps into a false gap
    if (serial_in) begin
      s_d.lo_cnt = 16'h0000;
      if (s_q.hi_cnt != 16'hffff) s_d.hi_cnt = s_q.hi_cnt + 16'h0001;
    end else if (s_q.lo_cnt != 16'hffff) begin
      s_d.lo_cnt = s_q.lo_cnt + 16'h0001;
    end
    // pulse ends on falling edge
    if (fall_edge) begin
      s_d.hi_cnt = 16'h0000;
      s_d.gap_seen = 1'b0;
      if (!s_q.half) begin
        s_d.half = 1'b1;
        s_d.first_wide = wide;
      end else begin
        s_d.half = 1'b0;
        if (dig == 2'h3) s_d.word_bad = 1'b1;
        if (int'(s_q.dig_idx) < n_addr) begin
          if (!addr_ok) s_d.word_bad = 1'b1;
        end else if (int'(s_q.dig_idx) < rcwd_pkg::WORD_DIGITS) begin
          s_d.nib_work[nib_pos] = (dig != rcwd_pkg::DIG_ZERO);
        end
        if (s_q.dig_idx != 4'hf) s_d.dig_idx = s_q.dig_idx + 4'h1;
      end
    end
    // end of word on gap
    // judged at the gap so a late digit cannot slip into the next word
    if (gap_hit) begin
      s_d.gap_seen = 1'b1;
      s_d.dig_idx = 4'h0;
      s_d.half = 1'b0;
      s_d.word_bad = 1'b0;
      if (s_q.word_bad || s_q.half || s_q.dig_idx != 4'(rcwd_pkg::WORD_DIGITS)) begin
        s_d.flag = 1'b0;
        s_d.phase = rcwd_pkg::RCWD_FIRST;
      end else begin
        case (s_q.phase)
          rcwd_pkg::RCWD_FIRST: begin
            s_d.nib_store = s_q.nib_work;
            s_d.phase = rcwd_pkg::RCWD_SECOND;
          end
          rcwd_pkg::RCWD_SECOND, rcwd_pkg::RCWD_HOLD: begin
            if (!DATA_VARIANT || s_q.nib_work == s_q.nib_store) begin
              s_d.nib_out = DATA_VARIANT ? s_q.nib_work : 4'h0;
              s_d.flag = 1'b1;
              s_d.phase = rcwd_pkg::RCWD_HOLD;
            end else begin
              s_d.flag = 1'b0;
              s_d.nib_store = s_q.nib_work;
              s_d.phase = rcwd_pkg::RCWD_SECOND;
            end
          end
          default: begin
            s_d.phase = rcwd_pkg::RCWD_FIRST;
          end
        endcase
      end
    end
    if (eot_hit) begin
      s_d.flag = 1'b0;
      s_d.phase = rcwd_pkg::RCWD_FIRST;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // async clear: first-word phase, all counts and outputs zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{phase: rcwd_pkg::RCWD_FIRST, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // outputs, straight from the state register
  // ------------------------------------------------------------
  assign word_pair_ok = s_q.flag;
  assign nibble_outputs = s_q.nib_out;

  // ------------------------------------------------------------
  // checks on the decoder's own behaviour
  // ------------------------------------------------------------
  // flag drops after long idle
  eot_drop_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    eot_hit |=> !word_pair_ok)
    else $error("flag held past idle");

  // output changes only with flag set
  nib_stable_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $changed(nibble_outputs) |-> word_pair_ok)
    else $error("nibble changed without flag");

  latch_with_flag_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $changed(nibble_outputs) |-> $rose(word_pair_ok))
    else $error("nibble changed without a flag rise");

  first_word_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (gap_hit && s_q.phase == rcwd_pkg::RCWD_FIRST) |=> !word_pair_ok && $stable(nibble_outputs))
    else $error("first word reached the outputs");

  bad_word_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (gap_hit && s_q.word_bad) |=> !word_pair_ok && s_q.phase == rcwd_pkg::RCWD_FIRST)
    else $error("bad word did not restart pairing");

  bad_digit_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (fall_edge && s_q.half && dig == 2'h3) |=> s_q.word_bad)
    else $error("malformed digit not marked");

  // flag rises only at word end
  gap_word_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(word_pair_ok) |-> $past(gap_hit))
    else $error("flag rose away from a word end");

  hold_phase_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    word_pair_ok |-> s_q.phase == rcwd_pkg::RCWD_HOLD)
    else $error("flag high outside the paired phase");

  addr_fail_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (fall_edge && s_q.half && int'(s_q.dig_idx) < n_addr && !addr_ok) |=> s_q.word_bad)
    else $error("address mismatch not marked");

  wide_class_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (fall_edge && !s_q.half) |=> s_q.first_wide == $past(wide))
    else $error("pulse width class lost");

  // open data digit stores a one
  open_one_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (fall_edge && s_q.half && int'(s_q.dig_idx) >= n_addr
      && int'(s_q.dig_idx) < rcwd_pkg::WORD_DIGITS && dig == rcwd_pkg::DIG_OPEN)
    |=> s_q.nib_work[$past(nib_pos)])
    else $error("open data digit not read as one");

endmodule : rcwd_decoder
`default_nettype wire

// ==== verification/rcwd_enc_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----
// encoder partner
// ----
module rcwd_enc_model (
  input wire logic ref_clk,
  input wire logic send_request_n,
  input wire logic [17:0] word_a,
  input wire logic [17:0] word_b,
  output logic serial_out,
  output logic busy
);
  // pulse of an 8 cycle period
  task automatic pulse(input bit wide);
    repeat (wide ? 6 : 2) @(posedge ref_clk) serial_out <= 1'b1;
    repeat (wide ? 2 : 6) @(posedge ref_clk) serial_out <= 1'b0;
  endtask : pulse
  // pulse pairs; code 3 is a malformed short-long pair
  task automatic send_word(input logic [17:0] w);
    for (int i = 0; i < 9; i++) begin
      pulse(w[2*i+:2] == 2'h1 || w[2*i+:2] == 2'h2);
      pulse(w[2*i+:2] == 2'h1 || w[2*i+:2] == 2'h3);
    end
    repeat (48) @(posedge ref_clk);
  endtask : send_word
  // two words per low request; line rests low between frames
  initial begin
    serial_out = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge ref_clk);
      if (!send_request_n) begin
        busy <= 1'b1;
        send_word(word_a);
        send_word(word_b);
        busy <= 1'b0;
      end
    end
  end
endmodule : rcwd_enc_model
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic send_n = 1'b1;
  logic [17:0] wa = 18'h0, wb = 18'h0, loc = 18'h0, t;
  logic serial, busy, flag1, flag2;
  logic [3:0] nib1, nib2, exp_nib = 4'h0;
  int num_errors = 0, check_count = 0, mode, n;
  int seed = 32'h9ee3ce0b;
  always #50 ref_clk = ~ref_clk;
  rcwd_enc_model i_enc (.ref_clk(ref_clk), .send_request_n(send_n), .word_a(wa),
    .word_b(wb), .serial_out(serial), .busy(busy));
  // short sim thresholds keep the run small; gap stays at 0.4 of eot
  localparam int SIM_WIDE = 4;
  localparam int SIM_GAP = 40;
  localparam int SIM_EOT = 100;
  rcwd_decoder #(.WIDE_CYC(SIM_WIDE), .GAP_CYC(SIM_GAP), .EOT_CYC(SIM_EOT)) i_dut (
    .ref_clk(ref_clk),
    .resetn(resetn), .serial_in(serial), .local_addr_digits(loc),
    .word_pair_ok(flag1), .nibble_outputs(nib1));
  rcwd_decoder #(.DATA_VARIANT(1'b0), .WIDE_CYC(SIM_WIDE), .GAP_CYC(SIM_GAP),
    .EOT_CYC(SIM_EOT)) i_dut2 (
    .ref_clk(ref_clk), .resetn(resetn), .serial_in(serial), .local_addr_digits(wa),
    .word_pair_ok(flag2), .nibble_outputs(nib2));
  task automatic check(input logic [3:0] got, input logic [3:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    if (num_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // open or one reads as logic one
  function automatic logic [3:0] nib_of(input logic [17:0] w);
    for (int i = 0; i < 4; i++) nib_of[i] = w[10+2*i+:2] != 2'h0;
  endfunction : nib_of
  // ----
  // main sequence: every mode first, then random
  // ----
  initial begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      @(posedge ref_clk);
      // pass 8 repeats a clean pair ahead of the mid-run reset
      mode = (k < 4 || k == 8) ? k % 8 : ($random(seed) & 3);
      for (int i = 0; i < 9; i++) t[2*i+:2] = 2'(($random(seed) & 32'h7fffffff) % 3);
      wa <= t;
      loc <= {t[17:2], (mode == 2) ? ((t[1:0] == 2'h2) ? 2'h0 : t[1:0] + 2'h1) : t[1:0]};
      if (mode == 1) t[11:10] = (t[11:10] == 2'h0) ? 2'h1 : 2'h0;
      if (mode == 3) t[17:16] = 2'h3;
      wb <= t;
      send_n <= 1'b0;
      @(posedge ref_clk);
      send_n <= 1'b1;
      if (mode == 0) exp_nib = nib_of(wa);
      repeat (3) @(posedge ref_clk);
      for (n = 0; busy && n < 2000; n++) @(posedge ref_clk);
      if (busy) begin
        num_errors++;
        tally_and_finish();
      end
      check(4'(flag1), 4'(mode == 0));
      check(nib1, exp_nib);
      check(4'(flag2), 4'(mode == 0 || mode == 2));
      check(nib2, 4'h0);
      // mid-run reset: outputs clear at once and stay clear after release
      if (k == 8) begin
        resetn <= 1'b0;
        @(posedge ref_clk);
        check(nib1, 4'h0);
        check(4'(flag1), 4'h0);
        resetn <= 1'b1;
        exp_nib = 4'h0;
        repeat (2) @(posedge ref_clk);
        check(nib1, 4'h0);
        check(4'(flag1), 4'h0);
      end
      repeat (110) @(posedge ref_clk);
      check(4'({flag1, flag2}), 4'h0);
    end
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
